/* verilog/stkmon_defines.svh */
`ifndef STKMON_DEFINES_SVH
`define STKMON_DEFINES_SVH

// ----------------------------------------------------------------
// monitor register addresses on the link
// ----------------------------------------------------------------
`define STKMON_CTRL_ADDR     20'hF00D8
`define STKMON_UPPER_ADDR    20'hF00DA
`define STKMON_LOWER_ADDR    20'hF00DC

// ----------------------------------------------------------------
// monitor fields and reset values
// ----------------------------------------------------------------
`define STKMON_ENABLE_BIT    7
`define STKMON_CTRL_RESET    8'h00
`define STKMON_UPPER_RESET   16'hFFFE
`define STKMON_LOWER_RESET   16'h0000

// ----------------------------------------------------------------
// cpu port apb offsets
// ----------------------------------------------------------------
`define STKMON_APB_ADDR      12'h000
`define STKMON_APB_WDATA     12'h004
`define STKMON_APB_CMD       12'h008
`define STKMON_APB_RDATA     12'h00C
`define STKMON_APB_SP        12'h010
`define STKMON_APB_STATUS    12'h014
`define STKMON_APB_MASK      12'h018

// ----------------------------------------------------------------
// cpu port fields and reset values
// ----------------------------------------------------------------
`define STKMON_CMD_WRITE_BIT 0
`define STKMON_CMD_BUSY_BIT  0
`define STKMON_RDATA_ERR_BIT 16
`define STKMON_ST_RANGE_BIT  0
`define STKMON_ST_PIN_BIT    1
`define STKMON_ST_DONE_BIT   2
`define STKMON_SP_RESET      16'h0000
`define STKMON_MASK_RESET    3'h0

`endif

/* verilog/stkmon_pkg.sv */
package stkmon_pkg;

	// cpu port sequencer states, gray along idle-issue-wait
	typedef enum logic [1:0] {
		STKMON_IDLE  = 2'b00,
		STKMON_ISSUE = 2'b01,
		STKMON_WAIT  = 2'b11
	} stkmon_state_type;

	// transfer width on the link
	typedef enum logic {
		STKMON_SIZE8  = 1'b0,
		STKMON_SIZE16 = 1'b1
	} stkmon_size_type;

endpackage : stkmon_pkg

/* verilog/stkmon_link_if.sv */
`timescale 1ns/100ps

interface stkmon_link_if;
	logic                       req;
	logic                       write;
	logic [19:0]                addr;
	stkmon_pkg::stkmon_size_type size;
	logic [15:0]                wdata;
	logic                       ack;
	logic                       err;
	logic [15:0]                rdata;
	logic [15:0]                stack_pointer;
	logic                       stack_range_irq;

	// the stack pointer monitor end
	modport monitor (
		input  req,
		input  write,
		input  addr,
		input  size,
		input  wdata,
		input  stack_pointer,
		output ack,
		output err,
		output rdata,
		output stack_range_irq
	);

	// the cpu end
	modport cpu (
		output req,
		output write,
		output addr,
		output size,
		output wdata,
		output stack_pointer,
		input  ack,
		input  err,
		input  rdata,
		input  stack_range_irq
	);
endinterface : stkmon_link_if

/* verilog/stkmon_range_check.sv */
`timescale 1ns/100ps

module stkmon_range_check (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        enable,
	input  wire logic [15:0] stack_pointer,
	input  wire logic [15:0] upper,
	input  wire logic [15:0] lower,
	output logic             out_of_range,
	output logic             entry_pulse
);
	wire beyond;

	// R1: above upper or below lower
	assign beyond = enable & ((stack_pointer > upper) | (stack_pointer < lower));

	// remember the last state and pulse only on entry
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_of_range <= 1'b0;
			entry_pulse  <= 1'b0;
		end else begin
			out_of_range <= beyond;
			// R8: silent while still outside
			entry_pulse  <= beyond & ~out_of_range;
		end
	end
endmodule : stkmon_range_check

/* verilog/stkmon_monitor.sv */
`timescale 1ns/100ps
`include "stkmon_defines.svh"

// What this block does
// R1: compare stack pointer, interrupt when outside
// R2: bit 7 enables monitoring, reset 00H
// R3: enable bit can only be set
// R4: limit writes ignored while enabled
// R5: upper limit bits 15..1, reset FFFEH
// R6: lower limit bits 15..1, reset 0000H
// R7: limit bit 0 always zero
// R8: no repeat detection while still outside
// R9: software returns pointer inside to re-arm
// R10: shares a vector with pin interrupt
// R11: control register 8-bit at F00D8H
// R12: limits 16-bit at F00DAH, F00DCH
// R13: pulse once on each range exit
module stkmon_monitor (
	input  wire logic         clk,
	input  wire logic         resetn,
	stkmon_link_if.monitor    link,
	output logic              monitor_enable,
	output logic              stack_out_of_range
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [15:1] upper_limit;
	logic [15:1] lower_limit;
	logic        ack_q;
	logic        err_q;
	logic [15:0] rdata_q;
	logic        irq_q;
	logic        next_enable;
	logic [15:1] next_upper;
	logic [15:1] next_lower;

	// full width limit views
	wire  [15:0] upper_word;
	wire  [15:0] lower_word;
	wire  [7:0]  ctrl_byte;

	// decode of the current request
	wire         hit_ctrl;
	wire         hit_upper;
	wire         hit_lower;
	wire         hit_any;
	wire         do_write;
	wire         wr_ctrl;
	wire         wr_upper;
	wire         wr_lower;
	wire  [15:0] read_mux;

	// range checker outputs
	wire         range_out;
	wire         range_entry;

	// ----------------------------------------------------------------
	// register views
	// ----------------------------------------------------------------

	// R7: bit 0 of each limit fixed low
	assign upper_word = {upper_limit, 1'b0};
	assign lower_word = {lower_limit, 1'b0};

	// R2: other control bits read zero
	assign ctrl_byte = {monitor_enable, 7'h00};

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------

	// R11: control only with byte transfers
	assign hit_ctrl = (link.addr == `STKMON_CTRL_ADDR)
		&& (link.size == stkmon_pkg::STKMON_SIZE8);

	// R12: limits only with halfword transfers
	assign hit_upper = (link.addr == `STKMON_UPPER_ADDR)
		&& (link.size == stkmon_pkg::STKMON_SIZE16);
	assign hit_lower = (link.addr == `STKMON_LOWER_ADDR)
		&& (link.size == stkmon_pkg::STKMON_SIZE16);

	assign hit_any  = hit_ctrl | hit_upper | hit_lower;
	assign do_write = link.req & link.write;
	assign wr_ctrl  = do_write & hit_ctrl;

	// R4: limits locked once enabled
	assign wr_upper = do_write & hit_upper & ~monitor_enable;
	assign wr_lower = do_write & hit_lower & ~monitor_enable;

	// read selection, zero for an unmapped access
	assign read_mux = hit_ctrl  ? {8'h00, ctrl_byte} :
	                  hit_upper ? upper_word :
	                  hit_lower ? lower_word :
	                  16'h0000;

	// ----------------------------------------------------------------
	// next values
	// ----------------------------------------------------------------

	// enable and limit update
	always_comb begin
		next_enable = monitor_enable;
		next_upper  = upper_limit;
		next_lower  = lower_limit;
		// R3: a one sets, a zero is ignored
		if (wr_ctrl && link.wdata[`STKMON_ENABLE_BIT]) begin
			next_enable = 1'b1;
		end
		// R5: upper limit keeps bits 15..1
		if (wr_upper) begin
			next_upper = link.wdata[15:1];
		end
		// R6: lower limit keeps bits 15..1
		if (wr_lower) begin
			next_lower = link.wdata[15:1];
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------

	// control and limit registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// R2: enable cleared at reset
			monitor_enable <= 1'(`STKMON_CTRL_RESET >> `STKMON_ENABLE_BIT);
			// R5: upper limit reset value
			upper_limit    <= 15'(`STKMON_UPPER_RESET >> 1);
			// R6: lower limit reset value
			lower_limit    <= 15'(`STKMON_LOWER_RESET >> 1);
		end else begin
			monitor_enable <= next_enable;
			upper_limit    <= next_upper;
			lower_limit    <= next_lower;
		end
	end

	// link answer, one cycle after the request
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_q   <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			ack_q <= link.req;
			err_q <= link.req & ~hit_any;
			if (link.req) begin
				rdata_q <= read_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// stack range watch
	// ----------------------------------------------------------------

	// R1: compare pointer against both limits
	stkmon_range_check u_range (
		.clk           (clk),
		.resetn        (resetn),
		.enable        (monitor_enable),
		.stack_pointer (link.stack_pointer),
		.upper         (upper_word),
		.lower         (lower_word),
		.out_of_range  (range_out),
		.entry_pulse   (range_entry)
	);

	// R13: one cycle request per exit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_q              <= 1'b0;
			stack_out_of_range <= 1'b0;
		end else begin
			irq_q              <= range_entry;
			stack_out_of_range <= range_out;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------

	// link answer and interrupt request
	assign link.ack             = ack_q;
	assign link.err             = err_q;
	assign link.rdata           = rdata_q;
	assign link.stack_range_irq = irq_q;

endmodule : stkmon_monitor

/* verilog/stkmon_cpu_port.sv */
`timescale 1ns/100ps
`include "stkmon_defines.svh"

module stkmon_cpu_port (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        external_pin_irq,
	output logic             irq,
	stkmon_link_if.cpu       link
);

	// ----------------------------------------------------------------
	// storage and decode
	// ----------------------------------------------------------------
	stkmon_pkg::stkmon_state_type state;
	stkmon_pkg::stkmon_state_type next_state;
	logic [19:0] link_addr;
	logic [15:0] link_wdata;
	logic        link_write;
	logic [15:0] rd_data;
	logic        rd_err;
	logic [15:0] stack_pointer;
	logic [2:0]  status;
	logic [2:0]  mask;
	logic        pin_q;
	wire         apb_wr;
	wire         hit_addr;
	wire         hit_wdata;
	wire         hit_cmd;
	wire         hit_rdata;
	wire         hit_sp;
	wire         hit_status;
	wire         hit_mask;
	wire         start;
	wire         done;
	wire  [2:0]  set_bits;
	wire  [2:0]  clr_bits;
	wire         is_half;

	// R12: limit addresses take halfword transfers
	function automatic logic size_is_half(input logic [19:0] a);
		size_is_half = (a == `STKMON_UPPER_ADDR) || (a == `STKMON_LOWER_ADDR);
	endfunction : size_is_half

	// register select
	assign apb_wr     = psel & penable & pwrite;
	assign hit_addr   = (paddr == `STKMON_APB_ADDR);
	assign hit_wdata  = (paddr == `STKMON_APB_WDATA);
	assign hit_cmd    = (paddr == `STKMON_APB_CMD);
	assign hit_rdata  = (paddr == `STKMON_APB_RDATA);
	assign hit_sp     = (paddr == `STKMON_APB_SP);
	assign hit_status = (paddr == `STKMON_APB_STATUS);
	assign hit_mask   = (paddr == `STKMON_APB_MASK);
	assign pready     = 1'b1;
	assign pslverr    = psel & penable & ~(hit_addr | hit_wdata | hit_cmd | hit_rdata
		| hit_sp | hit_status | hit_mask);

	// read mux
	assign prdata = hit_addr   ? {12'h000, link_addr} :
	                hit_wdata  ? {16'h0000, link_wdata} :
	                hit_cmd    ? {31'h0, state != stkmon_pkg::STKMON_IDLE} :
	                hit_rdata  ? {15'h0000, rd_err, rd_data} :
	                hit_sp     ? {16'h0000, stack_pointer} :
	                hit_status ? {29'h0, status} :
	                hit_mask   ? {29'h0, mask} :
	                32'h00000000;

	// ----------------------------------------------------------------
	// link sequencer
	// ----------------------------------------------------------------
	assign start = apb_wr & hit_cmd & (state == stkmon_pkg::STKMON_IDLE);
	assign done  = (state == stkmon_pkg::STKMON_WAIT) & link.ack;

	// idle, one cycle request, wait for the answer
	always_comb begin
		next_state = state;
		case (state)
			stkmon_pkg::STKMON_IDLE: begin
				if (start) begin
					next_state = stkmon_pkg::STKMON_ISSUE;
				end
			end
			stkmon_pkg::STKMON_ISSUE: begin
				next_state = stkmon_pkg::STKMON_WAIT;
			end
			stkmon_pkg::STKMON_WAIT: begin
				if (link.ack) begin
					next_state = stkmon_pkg::STKMON_IDLE;
				end
			end
			default: begin
				next_state = stkmon_pkg::STKMON_IDLE;
			end
		endcase
	end

	// link drive
	assign is_half      = size_is_half(link_addr);
	assign link.req     = (state == stkmon_pkg::STKMON_ISSUE);
	assign link.write   = link_write;
	assign link.addr    = link_addr;
	// R11: control address takes byte transfers
	assign link.size    = is_half ? stkmon_pkg::STKMON_SIZE16 : stkmon_pkg::STKMON_SIZE8;
	// R7: bit 0 of limit writes forced low
	assign link.wdata   = is_half ? {link_wdata[15:1], 1'b0} : link_wdata;
	// R9: software steers the pointer back inside
	assign link.stack_pointer = stack_pointer;

	// ----------------------------------------------------------------
	// interrupt status
	// ----------------------------------------------------------------

	// R10: range, pin and link done sources all share one output
	assign set_bits = {done, external_pin_irq & ~pin_q, link.stack_range_irq};
	assign clr_bits = (apb_wr & hit_status) ? pwdata[2:0] : 3'h0;
	assign irq      = |(status & mask);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------

	// software registers and sequencer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state         <= stkmon_pkg::STKMON_IDLE;
			link_addr     <= 20'h00000;
			link_wdata    <= 16'h0000;
			link_write    <= 1'b0;
			stack_pointer <= `STKMON_SP_RESET;
			mask          <= `STKMON_MASK_RESET;
		end else begin
			state <= next_state;
			if (apb_wr && hit_addr) begin
				link_addr <= pwdata[19:0];
			end
			if (apb_wr && hit_wdata) begin
				link_wdata <= pwdata[15:0];
			end
			if (start) begin
				link_write <= pwdata[`STKMON_CMD_WRITE_BIT];
			end
			if (apb_wr && hit_sp) begin
				stack_pointer <= pwdata[15:0];
			end
			if (apb_wr && hit_mask) begin
				mask <= pwdata[2:0];
			end
		end
	end

	// answer capture and sticky status, set wins over clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_data <= 16'h0000;
			rd_err  <= 1'b0;
			status  <= 3'h0;
			pin_q   <= 1'b0;
		end else begin
			if (done) begin
				rd_data <= link.rdata;
				rd_err  <= link.err;
			end
			status <= (status & ~clr_bits) | set_bits;
			pin_q  <= external_pin_irq;
		end
	end

endmodule : stkmon_cpu_port

/* bench/stkmon_props.sv */
`timescale 1ns/100ps
`include "stkmon_defines.svh"

module stkmon_props (
	input wire logic                        clk,
	input wire logic                        resetn,
	input wire logic                        req,
	input wire logic                        write,
	input wire logic [19:0]                 addr,
	input wire stkmon_pkg::stkmon_size_type size,
	input wire logic [15:0]                 wdata,
	input wire logic                        ack,
	input wire logic                        err,
	input wire logic [15:0]                 rdata,
	input wire logic [15:0]                 stack_pointer,
	input wire logic                        stack_range_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	logic en_seen;
	logic known;

	// --------------------------------------------------------
	// helper logic
	// --------------------------------------------------------
	// mapped addresses, and whether an enable was ever written
	assign known = addr == `STKMON_CTRL_ADDR || addr == `STKMON_UPPER_ADDR ||
		addr == `STKMON_LOWER_ADDR;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			en_seen <= 1'b0;
		else if (req && write && addr == `STKMON_CTRL_ADDR && wdata[7])
			en_seen <= 1'b1;
	end

	// --------------------------------------------------------
	// link and monitor properties
	// --------------------------------------------------------
	chk_ack_follows: assert property (req |=> ack)
		else $error("ack missing after request");
	chk_ack_cause: assert property (ack |-> $past(req))
		else $error("ack without request");
	chk_ctrl_zeros: assert property (
		req && !write && addr == `STKMON_CTRL_ADDR |=> rdata[6:0] == 7'h00 && rdata[15:8] == 8'h00)
		else $error("control spare bits not zero");
	chk_enable_sticky: assert property (
		req && !write && addr == `STKMON_CTRL_ADDR && en_seen |=> rdata[7])
		else $error("enable bit lost");
	chk_limit_bit0: assert property (
		req && !write && (addr == `STKMON_UPPER_ADDR || addr == `STKMON_LOWER_ADDR) |=> !rdata[0])
		else $error("limit bit 0 set");
	chk_unmapped_err: assert property (req && !known |=> err && rdata == 16'h0000)
		else $error("unmapped access not refused");
	chk_irq_single: assert property (stack_range_irq |=> !stack_range_irq)
		else $error("range request longer than one cycle");
	chk_no_repeat: assert property (
		stack_range_irq ##1 $stable(stack_pointer) [*4] |-> !stack_range_irq)
		else $error("repeated range request");
endmodule : stkmon_props

/* bench/stack_pointer_monitor_tb.sv */
`timescale 1ns/100ps
`include "stkmon_defines.svh"

module stack_pointer_monitor_tb;
	logic        clk, resetn, psel, penable, pwrite, pin, pready, pslverr, irq, mon_en, out_rng;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int          err_count, comparisons;

	stkmon_link_if link ();
	stkmon_monitor u_stkmon_monitor (.clk(clk), .resetn(resetn), .link(link.monitor),
		.monitor_enable(mon_en), .stack_out_of_range(out_rng));
	stkmon_cpu_port u_stkmon_cpu_port (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .external_pin_irq(pin), .irq(irq), .link(link.cpu));
	stkmon_props u_stkmon_props (.clk(clk), .resetn(resetn), .req(link.req), .write(link.write),
		.addr(link.addr), .size(link.size), .wdata(link.wdata), .ack(link.ack), .err(link.err),
		.rdata(link.rdata), .stack_pointer(link.stack_pointer),
		.stack_range_irq(link.stack_range_irq));

	// clock generation
	initial clk = 1'b0;
	always #20 clk = ~clk;

	// --------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------
	task end_sim;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer; answer taken at the edge where pready is high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic e);
		logic r;
		r = 1'b0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (int n = 0; n < 50 && !r; n++) begin
			@(posedge clk);
			r = pready;
			rd = prdata;
			e = pslverr;
		end
		if (!r) begin
			err_count++;
			end_sim;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] exp);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, exp);
	endtask : rd

	// one link transfer through the command registers
	task lk(input logic w, input logic [19:0] a, input logic [15:0] d);
		logic e;
		wr(`STKMON_APB_ADDR, {12'h000, a});
		wr(`STKMON_APB_WDATA, {16'h0000, d});
		wr(`STKMON_APB_CMD, {31'h0, w});
		q = 32'h1;
		for (int n = 0; n < 20 && q[0]; n++)
			apb(1'b0, `STKMON_APB_CMD, 32'h0, q, e);
		if (q[0]) begin
			err_count++;
			end_sim;
		end
		apb(1'b0, `STKMON_APB_RDATA, 32'h0, q, e);
	endtask : lk

	task chk_out(input logic ei, input logic ee);
		@(negedge clk);
		chk({30'h0, irq, mon_en}, {30'h0, ei, ee});
		@(posedge clk);
	endtask : chk_out

	task sp_status(input logic [15:0] sp, input logic [31:0] exp);
		wr(`STKMON_APB_SP, {16'h0000, sp});
		repeat (4) @(posedge clk);
		rd(`STKMON_APB_STATUS, exp);
	endtask : sp_status

	// --------------------------------------------------------
	// scenarios
	// --------------------------------------------------------
	task t_reset;
		lk(1'b0, `STKMON_CTRL_ADDR, 16'h0000);
		chk(q, 32'h0000_0000);
		lk(1'b0, `STKMON_UPPER_ADDR, 16'h0000);
		chk(q, 32'h0000_FFFE);
		lk(1'b0, `STKMON_LOWER_ADDR, 16'h0000);
		chk(q, 32'h0000_0000);
	endtask : t_reset

	task t_limits;
		lk(1'b1, `STKMON_UPPER_ADDR, 16'h8001);
		lk(1'b0, `STKMON_UPPER_ADDR, 16'h0000);
		chk(q, 32'h0000_8000);
		lk(1'b1, `STKMON_LOWER_ADDR, 16'h4000);
		lk(1'b0, `STKMON_LOWER_ADDR, 16'h0000);
		chk(q, 32'h0000_4000);
		wr(`STKMON_APB_MASK, 32'h4);
		chk_out(1'b1, 1'b0);
		wr(`STKMON_APB_STATUS, 32'h7);
		chk_out(1'b0, 1'b0);
	endtask : t_limits

	task t_errors;
		logic e;
		apb(1'b0, 12'h01C, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		lk(1'b0, 20'hF00D9, 16'h0000);
		chk(q, 32'h0001_0000);
	endtask : t_errors

	task t_range;
		sp_status(16'h9000, 32'h4);
		wr(`STKMON_APB_SP, 32'h6000);
		lk(1'b1, `STKMON_CTRL_ADDR, 16'h0080);
		wr(`STKMON_APB_STATUS, 32'h7);
		wr(`STKMON_APB_MASK, 32'h1);
		chk_out(1'b0, 1'b1);
		sp_status(16'h8000, 32'h0);
		chk({31'h0, out_rng}, 32'h0);
		sp_status(16'h8002, 32'h1);
		chk({31'h0, out_rng}, 32'h1);
		chk_out(1'b1, 1'b1);
		wr(`STKMON_APB_STATUS, 32'h1);
		sp_status(16'h9000, 32'h0);
		chk({31'h0, out_rng}, 32'h1);
		wr(`STKMON_APB_SP, 32'h6000);
		sp_status(16'h3FFE, 32'h1);
		wr(`STKMON_APB_STATUS, 32'h1);
	endtask : t_range

	task t_lock;
		lk(1'b1, `STKMON_CTRL_ADDR, 16'h0000);
		chk_out(1'b0, 1'b1);
		lk(1'b1, `STKMON_UPPER_ADDR, 16'h1234);
		lk(1'b0, `STKMON_UPPER_ADDR, 16'h0000);
		chk(q, 32'h0000_8000);
		lk(1'b1, `STKMON_LOWER_ADDR, 16'h0000);
		lk(1'b0, `STKMON_LOWER_ADDR, 16'h0000);
		chk(q, 32'h0000_4000);
	endtask : t_lock

	task t_pin;
		wr(`STKMON_APB_STATUS, 32'h7);
		wr(`STKMON_APB_MASK, 32'h0);
		pin <= 1'b1;
		repeat (3) @(posedge clk);
		chk_out(1'b0, 1'b1);
		rd(`STKMON_APB_STATUS, 32'h2);
		wr(`STKMON_APB_MASK, 32'h2);
		chk_out(1'b1, 1'b1);
		wr(`STKMON_APB_STATUS, 32'h2);
		pin <= 1'b0;
		chk_out(1'b0, 1'b1);
	endtask : t_pin

	// --------------------------------------------------------
	// main sequence
	// --------------------------------------------------------
	initial begin
		{resetn, psel, penable, pwrite, pin} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		err_count = 0;
		comparisons = 0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_reset;
		t_limits;
		t_errors;
		t_range;
		t_lock;
		t_pin;
		end_sim;
	end
endmodule : stack_pointer_monitor_tb
